// file: embc_asserts.sv
`timescale 1ns/1ps
module embc_asserts
   import embc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [CFG_W-1:0] cfg_pins,
   input wire logic ext_access_strap,
   input wire logic req_valid,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_write,
   input wire logic req_ready,
   input wire logic resp_valid,
   input wire logic resp_onchip,
   input wire logic ad_oe,
   input wire logic addr_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic upper_lane_strobe,
   input wire logic fetch_indicator,
   input wire logic bus_clock_out
);
   logic live_reg;
   logic live_next;
   logic bus_on;
   // Pins show port levels until config is in, so pin checks wait for it
   always_comb begin
      live_next = live_reg | req_ready;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         live_reg <= 1'b0;
      end else begin
         live_reg <= live_next;
      end
   end
   assign bus_on = live_reg & cfg_pins[CFG_BUS_EN];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_hit;
      ext_access_strap && req_addr >= ONCHIP_LO && req_addr <= ONCHIP_HI;
   endsequence
   sequence s_full_wr;
      req_write && !ext_access_strap && cfg_pins[CFG_BUS_EN]
         && !cfg_pins[CFG_WRL_STYLE];
   endsequence
   a_clock_half: assert property (
      live_reg && bus_clock_out |=> !bus_clock_out ##1 bus_clock_out)
      else $error("bus clock not at half rate");
   a_ready_boundary: assert property (req_ready |-> bus_clock_out)
      else $error("request taken off a state boundary");
   a_one_outstanding: assert property (s_take |=> !req_ready)
      else $error("request taken while busy");
   a_resp_pulse: assert property (resp_valid |=> !resp_valid)
      else $error("response longer than one cycle");
   a_onchip_hit: assert property (
      s_take ##0 s_hit |=> resp_valid && resp_onchip)
      else $error("window access not served on chip");
   a_strap_low_ext: assert property (
      resp_valid && !ext_access_strap |-> !resp_onchip)
      else $error("on chip service with strap low");
   a_read_ext: assert property (
      bus_on && !read_strobe_n |-> !ad_oe && write_strobe_n)
      else $error("read strobe outside a read");
   a_write_drive: assert property (
      bus_on && !(write_strobe_n && upper_lane_strobe) |->
      ad_oe && read_strobe_n)
      else $error("write strobe outside a write");
   a_fetch_start: assert property (
      bus_on && $rose(fetch_indicator) |-> ad_oe && read_strobe_n)
      else $error("fetch flag outside an address state");
   a_strobe_idle: assert property (
      bus_on && resp_valid && !resp_onchip |->
      addr_strobe == !cfg_pins[CFG_ALE_STYLE])
      else $error("address strobe not idle at cycle end");
   a_write_strobe: assert property (
      s_take ##0 s_full_wr |-> ##[2:8] !write_strobe_n)
      else $error("full write strobe missing");
endmodule

// file: embc_bus_ctrl.sv
`timescale 1ns/1ps
module embc_bus_ctrl
   import embc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [CFG_W-1:0] cfg_pins,
   input wire logic ext_access_strap,
   input wire logic req_valid,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_write,
   input wire logic req_fetch,
   input wire logic [1:0] req_be,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [DATA_W-1:0] onchip_rdata,
   input wire logic [PORT_W-1:0] port_out,
   input wire logic [DATA_W-1:0] ad_in,
   input wire logic ready_in,
   input wire logic width_select_in,
   output logic req_ready,
   output logic resp_valid,
   output logic resp_onchip,
   output logic [DATA_W-1:0] resp_rdata,
   output logic [DATA_W-1:0] ad_out,
   output logic ad_oe,
   output logic addr_strobe,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic upper_lane_strobe,
   output logic fetch_indicator,
   output logic bus_clock_out
);
   localparam int SYNC_W = CFG_W + DATA_W + 3;
   embc_sync_if #(.W(SYNC_W)) sync_bus ();
   assign sync_bus.raw = {cfg_pins, ad_in, ext_access_strap, ready_in,
                          width_select_in};
   embc_sync #(.W(SYNC_W)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .port(sync_bus)
   );
   logic [CFG_W-1:0] cfg_s;
   logic [DATA_W-1:0] ad_s;
   logic strap_s;
   logic ready_s;
   logic width_s;
   assign {cfg_s, ad_s, strap_s, ready_s, width_s} = sync_bus.stable;
   embc_state_t state_reg, state_next;
   logic [2:0] init_cnt_reg, init_cnt_next;
   logic loaded_reg, loaded_next;
   logic [CFG_W-1:0] chip_config_reg, chip_config_next;
   logic strap_reg, strap_next;
   logic phase_reg, phase_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic [1:0] be_reg, be_next;
   logic write_reg, write_next;
   logic fetch_reg, fetch_next;
   logic wide_reg, wide_next;
   logic hi_reg, hi_next;
   logic [1:0] dcnt_reg, dcnt_next;
   logic req_ready_reg, req_ready_next;
   logic resp_valid_reg, resp_valid_next;
   logic resp_onchip_reg, resp_onchip_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [DATA_W-1:0] ad_out_reg, ad_out_next;
   logic ad_oe_reg, ad_oe_next;
   logic [PORT_W-1:0] pins_reg, pins_next;
   logic accept;
   logic onchip_hit;
   logic dyn_width;
   logic in_cycle;
   logic odd_byte;
   logic even_byte;
   logic [PORT_W-1:0] bus_pins;
   assign accept = req_valid && req_ready_reg;
   assign onchip_hit = strap_reg && req_addr >= ONCHIP_LO &&
                       req_addr <= ONCHIP_HI;
   assign dyn_width = chip_config_reg[CFG_WIDTH_LO] &&
                      chip_config_reg[CFG_WIDTH_HI];
   // Sequencing: one bus state is two oscillator cycles, phase 1 ends it
   always_comb begin
      state_next = state_reg;
      init_cnt_next = init_cnt_reg;
      loaded_next = loaded_reg;
      chip_config_next = chip_config_reg;
      strap_next = strap_reg;
      phase_next = ~phase_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      be_next = be_reg;
      write_next = write_reg;
      fetch_next = fetch_reg;
      wide_next = wide_reg;
      hi_next = hi_reg;
      dcnt_next = dcnt_reg;
      resp_valid_next = 1'b0;
      resp_onchip_next = resp_onchip_reg;
      rdata_next = rdata_reg;
      // Strap and config are caught once the synchroniser has settled
      if (!loaded_reg) begin
         if (init_cnt_reg == INIT_CYCLES) begin
            loaded_next = 1'b1;
            chip_config_next = cfg_s;
            strap_next = strap_s;
         end else begin
            init_cnt_next = init_cnt_reg + 3'h1;
         end
      end
      case (state_reg)
         EMBC_IDLE: begin
            if (accept) begin
               addr_next = req_addr;
               wdata_next = req_wdata;
               be_next = req_be;
               write_next = req_write;
               fetch_next = req_fetch;
               hi_next = (req_be == 2'b10);
               if (onchip_hit) begin
                  resp_valid_next = 1'b1;
                  resp_onchip_next = 1'b1;
                  rdata_next = onchip_rdata;
               end else begin
                  resp_onchip_next = 1'b0;
                  rdata_next = '0;
                  state_next = EMBC_ADDR;
               end
            end
         end
         EMBC_ADDR: begin
            if (phase_reg) begin
               // Width is settled per cycle while the address is out
               wide_next = dyn_width ? width_s :
                           chip_config_reg[CFG_WIDTH_LO];
               dcnt_next = 2'h0;
               state_next = EMBC_DATA;
            end
         end
         EMBC_DATA: begin
            if (phase_reg) begin
               if (dcnt_reg < MIN_DATA_STATES - 2'h1) begin
                  dcnt_next = dcnt_reg + 2'h1;
               end else if (ready_s) begin
                  if (!write_reg) begin
                     if (wide_reg) begin
                        rdata_next = ad_s;
                     end else if (hi_reg) begin
                        rdata_next[15:8] = ad_s[7:0];
                     end else begin
                        rdata_next[7:0] = ad_s[7:0];
                     end
                  end
                  state_next = EMBC_END;
               end
            end
         end
         EMBC_END: begin
            if (phase_reg) begin
               // A narrow bus splits a word into low byte then high byte
               if (!wide_reg && !hi_reg && be_reg == 2'b11) begin
                  hi_next = 1'b1;
                  state_next = EMBC_ADDR;
               end else begin
                  resp_valid_next = 1'b1;
                  state_next = EMBC_IDLE;
               end
            end
         end
         default: begin
            state_next = EMBC_IDLE;
         end
      endcase
   end

   // Requests are taken only on a bus state boundary
   assign req_ready_next = loaded_next && state_next == EMBC_IDLE &&
                           phase_reg == 1'b0 && !accept;
   assign in_cycle = state_next != EMBC_IDLE;
   assign odd_byte = wide_next ? be_next[1] : hi_next;
   assign even_byte = wide_next ? be_next[0] : !hi_next;
   // Pin levels, derived from the next state so they leave a flop
   always_comb begin
      bus_pins = '0;
      ad_out_next = '0;
      ad_oe_next = 1'b0;
      if (chip_config_reg[CFG_ALE_STYLE]) begin
         bus_pins[PIN_ADDR_STROBE] = state_next == EMBC_ADDR;
      end else begin
         bus_pins[PIN_ADDR_STROBE] = !(state_next == EMBC_ADDR ||
                                       state_next == EMBC_DATA);
      end
      bus_pins[PIN_FETCH] = in_cycle && fetch_next;
      bus_pins[PIN_READ] = !(state_next == EMBC_DATA && !write_next);
      bus_pins[PIN_WRITE] = 1'b1;
      bus_pins[PIN_UPPER] = 1'b1;
      if (state_next == EMBC_DATA && write_next) begin
         bus_pins[PIN_WRITE] = !(!chip_config_reg[CFG_WRL_STYLE] ||
                                 even_byte);
         if (chip_config_reg[CFG_WRH_STYLE]) begin
            bus_pins[PIN_UPPER] = !odd_byte;
         end else begin
            bus_pins[PIN_UPPER] = !(wide_next && be_next[1]);
         end
      end
      if (state_next == EMBC_ADDR) begin
         // Address bit 0 names the byte on a narrow bus
         ad_out_next = {addr_next[15:1], hi_next | addr_next[0]};
         ad_oe_next = 1'b1;
      end else if (state_next == EMBC_DATA && write_next) begin
         if (wide_next) begin
            ad_out_next = wdata_next;
         end else begin
            ad_out_next = {8'h00, hi_next ? wdata_next[15:8]
                                          : wdata_next[7:0]};
         end
         ad_oe_next = 1'b1;
      end
      pins_next = chip_config_reg[CFG_BUS_EN] ? bus_pins : port_out;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= EMBC_IDLE;
         init_cnt_reg <= 3'h0;
         loaded_reg <= 1'b0;
         chip_config_reg <= CFG_RESET;
         strap_reg <= 1'b0;
         phase_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         be_reg <= 2'h0;
         write_reg <= 1'b0;
         fetch_reg <= 1'b0;
         wide_reg <= 1'b0;
         hi_reg <= 1'b0;
         dcnt_reg <= 2'h0;
         req_ready_reg <= 1'b0;
         resp_valid_reg <= 1'b0;
         resp_onchip_reg <= 1'b0;
         rdata_reg <= '0;
         ad_out_reg <= '0;
         ad_oe_reg <= 1'b0;
         pins_reg <= 5'h0d;
      end else begin
         state_reg <= state_next;
         init_cnt_reg <= init_cnt_next;
         loaded_reg <= loaded_next;
         chip_config_reg <= chip_config_next;
         strap_reg <= strap_next;
         phase_reg <= phase_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         be_reg <= be_next;
         write_reg <= write_next;
         fetch_reg <= fetch_next;
         wide_reg <= wide_next;
         hi_reg <= hi_next;
         dcnt_reg <= dcnt_next;
         req_ready_reg <= req_ready_next;
         resp_valid_reg <= resp_valid_next;
         resp_onchip_reg <= resp_onchip_next;
         rdata_reg <= rdata_next;
         ad_out_reg <= ad_out_next;
         ad_oe_reg <= ad_oe_next;
         pins_reg <= pins_next;
      end
   end
   assign req_ready = req_ready_reg;
   assign resp_valid = resp_valid_reg;
   assign resp_onchip = resp_onchip_reg;
   assign resp_rdata = rdata_reg;
   assign ad_out = ad_out_reg;
   assign ad_oe = ad_oe_reg;
   assign addr_strobe = pins_reg[PIN_ADDR_STROBE];
   assign fetch_indicator = pins_reg[PIN_FETCH];
   assign write_strobe_n = pins_reg[PIN_WRITE];
   assign read_strobe_n = pins_reg[PIN_READ];
   assign upper_lane_strobe = pins_reg[PIN_UPPER];
   assign bus_clock_out = phase_reg;
endmodule

// file: embc_mem_model.sv
`timescale 1ns/1ps
module embc_mem_model
   import embc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [DATA_W-1:0] ad_out,
   input wire logic ad_oe,
   input wire logic addr_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic upper_lane_strobe,
   input wire logic fetch_indicator,
   input wire logic ale,
   input wire logic wide,
   input wire logic [3:0] wait_n,
   output logic [DATA_W-1:0] ad_in,
   output logic ready_in
);
   logic [ADDR_W-1:0] lat_addr = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic [DATA_W-1:0] rdat;
   logic p_as = 1'b1, p_rd = 1'b1, p_wr = 1'b1, p_up = 1'b1;
   int n_rd = 0, n_wr = 0, n_up = 0, n_fe = 0, wcnt = 0;
   initial ready_in = 1'b1;
   assign rdat = wide ? {(lat_addr[7:0] | 8'h01) ^ 8'h5a,
      (lat_addr[7:0] & 8'hfe) ^ 8'h5a} : {8'hff, lat_addr[7:0] ^ 8'h5a};
   // Pull-ups hold a released bus high; early data is garbage
   assign ad_in = ad_oe ? ad_out : (read_strobe_n ? 16'hffff :
      (ready_in ? rdat : ~rdat));
   always @(posedge clk_sys) begin
      if (ale ? addr_strobe : (!addr_strobe && p_as)) begin
         lat_addr = ad_out;
      end
      if ((!read_strobe_n && p_rd) || (!write_strobe_n && p_wr)) begin
         wcnt = 2 * wait_n;
      end else if (wcnt > 0) begin
         wcnt--;
      end
      if (!read_strobe_n && p_rd) begin
         n_rd++;
         n_fe += fetch_indicator;
      end
      if (!write_strobe_n && p_wr) n_wr++;
      if (!upper_lane_strobe && p_up) n_up++;
      if (!write_strobe_n || !upper_lane_strobe) wr_data = ad_out;
      // Slow memory holds ready low until its count runs out
      ready_in <= wait_n == 0 || (wcnt == 0 && (!read_strobe_n ||
         !write_strobe_n));
      p_as = addr_strobe;
      p_rd = read_strobe_n;
      p_wr = write_strobe_n;
      p_up = upper_lane_strobe;
   end
endmodule

// file: embc_pkg.sv
package embc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int CFG_W = 6;
   localparam int PORT_W = 5;

   // Chip configuration field positions
   localparam int CFG_ALE_STYLE = 0;
   localparam int CFG_WIDTH_LO = 1;
   localparam int CFG_WIDTH_HI = 2;
   localparam int CFG_WRH_STYLE = 3;
   localparam int CFG_WRL_STYLE = 4;
   localparam int CFG_BUS_EN = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

   // On-chip program memory window, used only when the strap reads one
   localparam logic [ADDR_W-1:0] ONCHIP_LO = 16'h2000;
   localparam logic [ADDR_W-1:0] ONCHIP_HI = 16'h5fff;

   // Cycles after reset release before strap and config are trusted
   localparam logic [2:0] INIT_CYCLES = 3'h5;
   // Least number of bus states in the data phase; three, so that read
   // data seen through the pin synchroniser has settled at the last one
   localparam logic [1:0] MIN_DATA_STATES = 2'h3;

   // Port pin order when the bus function is off
   localparam int PIN_ADDR_STROBE = 0;
   localparam int PIN_FETCH = 1;
   localparam int PIN_WRITE = 2;
   localparam int PIN_READ = 3;
   localparam int PIN_UPPER = 4;

   typedef enum logic [1:0] {
      EMBC_IDLE,
      EMBC_ADDR,
      EMBC_DATA,
      EMBC_END
   } embc_state_t;
endpackage

// file: embc_sync.sv
`timescale 1ns/1ps
module embc_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   embc_sync_if.sync port
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] out_reg;
   logic [W-1:0] out_next;

   // A bit moves only once the second and third stage agree
   always_comb begin
      out_next = out_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            out_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         out_reg <= '0;
      end else begin
         s1_reg <= port.raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign port.stable = out_reg;
endmodule

// file: embc_sync_if.sv
`timescale 1ns/1ps
interface embc_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] stable;
   modport src (output raw, input stable);
   modport sync (input raw, output stable);
endinterface

// file: embc_tb.sv
`timescale 1ns/1ps
module testbench
   import embc_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, ext_access_strap = 1'b0;
   logic req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
   logic width_select_in = 1'b0, wide = 1'b1, ale = 1'b0;
   logic [CFG_W-1:0] cfg_pins = '0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [1:0] req_be = '0;
   logic [DATA_W-1:0] req_wdata = '0, onchip_rdata = '0;
   logic [PORT_W-1:0] port_out = '0;
   logic [3:0] wait_n = '0;
   logic req_ready, resp_valid, resp_onchip, ad_oe, addr_strobe, ready_in;
   logic read_strobe_n, write_strobe_n, upper_lane_strobe;
   logic fetch_indicator, bus_clock_out;
   logic [DATA_W-1:0] resp_rdata, ad_out, ad_in;
   int err_count = 0, n_compared = 0;
   embc_bus_ctrl i_embc_bus_ctrl (.clk_sys, .rst_n, .cfg_pins,
      .ext_access_strap, .req_valid, .req_addr, .req_write, .req_fetch,
      .req_be, .req_wdata, .onchip_rdata, .port_out, .ad_in, .ready_in,
      .width_select_in, .req_ready, .resp_valid, .resp_onchip, .resp_rdata,
      .ad_out, .ad_oe, .addr_strobe, .read_strobe_n, .write_strobe_n,
      .upper_lane_strobe, .fetch_indicator, .bus_clock_out);
   embc_mem_model i_embc_mem_model (.clk_sys, .ad_out, .ad_oe,
      .addr_strobe, .read_strobe_n, .write_strobe_n, .upper_lane_strobe,
      .fetch_indicator, .ale, .wide, .wait_n, .ad_in, .ready_in);
   always #25 clk_sys = ~clk_sys;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Which = 1 waits for the response, 0 for req_ready to be seen high
   task automatic wait_hi(input bit which, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge clk_sys);
         if ((which ? resp_valid : req_ready) === 1'b1) return;
      end
      err_count++;
      summarize();
   endtask
   task automatic do_reset(input logic [5:0] cfg, input logic strap);
      rst_n <= 1'b0;
      cfg_pins <= cfg;
      ext_access_strap <= strap;
      ale <= cfg[CFG_ALE_STYLE];
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      if (cfg[CFG_BUS_EN]) wait_hi(0, 40);
      else repeat (10) @(posedge clk_sys);
   endtask
   task automatic xfer(input logic [15:0] a, input logic wr, input logic fe,
      input logic [1:0] be, input logic [15:0] wd);
      req_valid <= 1'b1;
      req_addr <= a;
      req_write <= wr;
      req_fetch <= fe;
      req_be <= be;
      req_wdata <= wd;
      wait_hi(0, 40);
      req_valid <= 1'b0;
      wait_hi(1, 300);
   endtask
   function automatic logic [15:0] rexp(input logic [15:0] a);
      return {a[7:0] ^ 8'h5b, a[7:0] ^ 8'h5a};
   endfunction
   task automatic t_bus_off();
      logic [4:0] p;
      logic b;
      do_reset(6'h00, 1'b0);
      for (int i = 0; i < 4; i++) begin
         p = 5'h15 ^ (5'h03 << i);
         port_out <= p;
         repeat (3) @(posedge clk_sys);
         chk({upper_lane_strobe, read_strobe_n, write_strobe_n,
            fetch_indicator, addr_strobe}, p);
         b = bus_clock_out;
         @(posedge clk_sys);
         chk(bus_clock_out, !b);
      end
   endtask
   task automatic t_onchip();
      logic [15:0] a [4] = '{16'h2000, 16'h5ffe, 16'h6000, 16'h1ffe};
      logic hit;
      do_reset(6'h22, 1'b1);
      onchip_rdata <= 16'h1234;
      for (int i = 0; i < 4; i++) begin
         hit = a[i] >= ONCHIP_LO && a[i] <= ONCHIP_HI;
         xfer(a[i], 1'b0, 1'b0, 2'b11, 16'h0000);
         chk(resp_onchip, hit);
         chk(resp_rdata, hit ? 16'h1234 : rexp(a[i]));
      end
   endtask
   task automatic t_write16();
      int u;
      int f;
      do_reset(6'h22, 1'b0);
      wait_n <= 4'h1;
      u = i_embc_mem_model.n_up;
      f = i_embc_mem_model.n_fe;
      xfer(16'h2000, 1'b1, 1'b0, 2'b11, 16'hbeef);
      chk(i_embc_mem_model.lat_addr, 16'h2000);
      chk(i_embc_mem_model.wr_data, 16'hbeef);
      chk(16'(i_embc_mem_model.n_up - u), 16'h0001);
      chk(addr_strobe, 1'b1);
      xfer(16'h2000, 1'b0, 1'b0, 2'b11, 16'h0000);
      chk(resp_onchip, 1'b0);
      chk(resp_rdata, rexp(16'h2000));
      chk(16'(i_embc_mem_model.n_fe - f), 16'h0000);
   endtask
   task automatic t_width();
      logic [5:0] cf [4] = '{6'h27, 6'h27, 6'h21, 6'h23};
      logic [3:0] ws = 4'b0110;
      logic [3:0] wd = 4'b1010;
      int c;
      int f;
      for (int r = 0; r < 4; r++) begin
         width_select_in <= ws[r];
         wide <= wd[r];
         wait_n <= 4'h2;
         do_reset(cf[r], 1'b0);
         c = i_embc_mem_model.n_rd;
         f = i_embc_mem_model.n_fe;
         xfer(16'h3004, 1'b0, 1'b1, 2'b11, 16'h0000);
         chk(resp_rdata, rexp(16'h3004));
         chk(16'(i_embc_mem_model.n_rd - c), wd[r] ? 16'h1 : 16'h2);
         chk(16'(i_embc_mem_model.n_fe - c + c - f),
            wd[r] ? 16'h1 : 16'h2);
      end
   endtask
   task automatic t_split();
      int u;
      int w;
      wide <= 1'b1;
      wait_n <= 4'h0;
      do_reset(6'h3a, 1'b0);
      u = i_embc_mem_model.n_up;
      w = i_embc_mem_model.n_wr;
      xfer(16'h2001, 1'b1, 1'b0, 2'b10, 16'hab00);
      chk(16'(i_embc_mem_model.n_up - u), 16'h0001);
      chk(16'(i_embc_mem_model.n_wr - w), 16'h0000);
      xfer(16'h2002, 1'b1, 1'b0, 2'b01, 16'h00cd);
      chk(16'(i_embc_mem_model.n_up - u), 16'h0001);
      chk(16'(i_embc_mem_model.n_wr - w), 16'h0001);
      chk(i_embc_mem_model.wr_data[7:0], 8'hcd);
   endtask
   initial begin
      t_bus_off();
      t_onchip();
      t_write16();
      t_width();
      t_split();
      summarize();
   end
endmodule
bind embc_bus_ctrl embc_asserts i_embc_asserts (.clk_sys, .rst_n,
   .cfg_pins, .ext_access_strap, .req_valid, .req_addr, .req_write,
   .req_ready, .resp_valid, .resp_onchip, .ad_oe, .addr_strobe,
   .read_strobe_n, .write_strobe_n, .upper_lane_strobe, .fetch_indicator,
   .bus_clock_out);
